// *** testbench/fscs_ctrl_model.sv ***
// Safety controller model that reads and writes the image bytes
`timescale 1ns/100ps
module fscs_ctrl_model (
    // Clock
    input  wire logic        CLK,
    // Image port
    output logic [15:0]      IMG_ADDR,
    output logic             IMG_RD,
    output logic             IMG_WR,
    output logic [7:0]       IMG_WDATA
);
    initial begin
        IMG_ADDR  = 16'h0000;
        IMG_RD    = 1'h0;
        IMG_WR    = 1'h0;
        IMG_WDATA = 8'h00;
    end

    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        IMG_ADDR  <= a;
        IMG_WDATA <= d;
        IMG_RD    <= !w;
        IMG_WR    <= w;
        @(posedge CLK);
        IMG_RD    <= 1'h0;
        IMG_WR    <= 1'h0;
        // Released lines flip so a stale value never passes
        IMG_ADDR  <= ~a;
        IMG_WDATA <= ~d;
    endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench of the fail-safe channel status byte
`timescale 1ns/100ps
module tb_top;
    import fscs_pkg::*;
    logic               CLK = 1'h0;
    logic               RST_B = 1'h1;
    logic               CE = 1'h1;
    logic [3:0]         pin = 4'h0;
    logic [3:0]         ADDR = 4'h0;
    logic [7:0]         WDATA = 8'h00;
    logic               WR = 1'h0;
    logic               RD = 1'h0;
    logic [7:0]         RDATA, IMG_RDATA, IMG_WDATA, e;
    logic [3:0]         STD_DI;
    logic               IRQ, IMG_RD, IMG_WR, rd_q = 1'h0, img_q = 1'h0;
    logic [15:0]        IMG_ADDR, base, note;
    fscs_proto_t        PROTO_TX = '0;
    fscs_proto_t        PROTO_RX;
    logic [15:0]        q[$];
    integer             seed, error_cnt = 0, n_tests = 0, cyc = 0;

    always #5 CLK = ~CLK;

    fscs_status u_fscs_status (.CLK(CLK), .RST_B(RST_B), .CE(CE),
        .SAFE_INPUT_0(pin[0]), .SAFE_INPUT_1(pin[1]), .SAFE_INPUT_2(pin[2]),
        .SAFE_INPUT_3(pin[3]), .STD_DI(STD_DI), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .IMG_ADDR(IMG_ADDR), .IMG_RD(IMG_RD),
        .IMG_WR(IMG_WR), .IMG_WDATA(IMG_WDATA), .IMG_RDATA(IMG_RDATA),
        .PROTO_TX(PROTO_TX), .PROTO_RX(PROTO_RX));

    fscs_ctrl_model u_fscs_ctrl_model (.CLK(CLK), .IMG_ADDR(IMG_ADDR), .IMG_RD(IMG_RD),
        .IMG_WR(IMG_WR), .IMG_WDATA(IMG_WDATA));

    function automatic logic [7:0] exp_st(input logic [3:0] c, input logic [3:0] p);
        logic [7:0] s;
        s = 8'h00;
        if (c[1:0] == 2'h1)
            s[5:4] = p[1:0];
        if (c[1:0] == 2'h2)
            s[0] = p[0] & p[1];
        if (c[3:2] == 2'h1)
            s[7:6] = p[3:2];
        if (c[3:2] == 2'h2)
            s[1] = p[2] & p[3];
        return s;
    endfunction

    function automatic logic [3:0] used(input logic [3:0] c);
        return {{2{c[3:2] == 2'h1 || c[3:2] == 2'h2}}, {2{c[1:0] == 2'h1 || c[1:0] == 2'h2}}};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_tests++;
        if (g !== x) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'h1;
        @(posedge CLK);
        WR    <= 1'h0;
    endtask

    // Expected value noted with a mask of the bits that count
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m);
        q.push_back({m, x});
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'h1;
        @(posedge CLK);
        RD   <= 1'h0;
    endtask

    task automatic img_rd(input logic [15:0] a, input logic [7:0] x);
        q.push_back({8'hFF, x});
        u_fscs_ctrl_model.acc(1'h0, a, 8'h00);
    endtask

    // Result sampled mid-cycle, one cycle after the strobe
    always @(posedge CLK) begin
        rd_q  <= RD;
        img_q <= IMG_RD;
    end
    always @(negedge CLK) begin
        if (rd_q || img_q) begin
            note = q.pop_front();
            chk((rd_q ? RDATA : IMG_RDATA) & note[15:8], note[7:0] & note[15:8]);
        end
    end

    task automatic settle();
        repeat (10) @(posedge CLK);
        @(negedge CLK);
    endtask

    task conclude();
        $display("Errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Ceiling well above the fewer than a thousand cycles the run needs
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        seed = 98;
        // Real falling edge, so the asynchronous clear fires before the first edge
        RST_B <= 1'h0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'h1;
        reg_rd(FSCS_REG_STATUS, 8'h00, 8'hFF);
        base = 16'($random(seed));
        reg_wr(FSCS_REG_BASE_LO, base[7:0]);
        reg_wr(FSCS_REG_BASE_HI, base[15:8]);
        // Every code pair, the unused code 3 included
        for (int c = 0; c < 16; c++) begin
            reg_wr(FSCS_REG_CFG, {4'h0, 4'(c)});
            repeat (3) begin
                pin <= 4'($random(seed));
                settle();
                e = exp_st(4'(c), pin);
                chk({4'h0, STD_DI}, {4'h0, pin & ~used(4'(c))});
                reg_rd(FSCS_REG_STATUS, e, 8'hFF);
                img_rd(base, e);
            end
        end
        reg_wr(FSCS_REG_CFG, 8'h05);
        PROTO_TX <= $random(seed);
        pin <= 4'hF;
        settle();
        for (int k = 1; k < 5; k++)
            img_rd(base + 16'(k), PROTO_TX[k - 1]);
        img_rd(base + 16'h0005, 8'h00);
        img_rd(base - 16'h0001, 8'h00);
        e = 8'($random(seed));
        u_fscs_ctrl_model.acc(1'h1, base + 16'h0002, e);
        u_fscs_ctrl_model.acc(1'h1, base + 16'h0003, ~e);
        u_fscs_ctrl_model.acc(1'h1, base + 16'h0004, e);
        @(negedge CLK);
        chk(PROTO_RX[2], e);
        chk(PROTO_RX[3], ~e);
        chk(PROTO_RX[0], 8'h00);
        reg_rd(4'hF, 8'h00, 8'hFF);
        reg_wr(FSCS_REG_STATUS, 8'h00);
        reg_rd(FSCS_REG_STATUS, 8'hF0, 8'hFF);
        // Interrupt: raise, mask, unmask, clear by read
        reg_wr(FSCS_REG_MASK, 8'h01);
        reg_rd(FSCS_REG_IRQ, 8'h00, 8'h00);
        pin <= 4'h0;
        settle();
        chk({7'h00, IRQ}, 8'h01);
        reg_wr(FSCS_REG_MASK, 8'h00);
        @(negedge CLK);
        chk({7'h00, IRQ}, 8'h00);
        reg_wr(FSCS_REG_MASK, 8'h01);
        @(negedge CLK);
        chk({7'h00, IRQ}, 8'h01);
        reg_rd(FSCS_REG_IRQ, 8'h01, 8'h01);
        @(negedge CLK);
        chk({7'h00, IRQ}, 8'h00);
        // Contact mismatch on pair 0 only; a lasting fault survives the clearing read
        reg_wr(FSCS_REG_CFG, 8'h0A);
        pin <= 4'h1;
        settle();
        reg_rd(FSCS_REG_IRQ, 8'h02, 8'h06);
        reg_rd(FSCS_REG_IRQ, 8'h02, 8'h02);
        // Enable low freezes the input path
        reg_wr(FSCS_REG_CFG, 8'h00);
        pin <= 4'h0;
        settle();
        @(posedge CLK);
        CE  <= 1'h0;
        pin <= 4'hA;
        settle();
        chk({4'h0, STD_DI}, 8'h00);
        @(posedge CLK);
        CE <= 1'h1;
        settle();
        chk({4'h0, STD_DI}, 8'h0A);
        repeat (3) @(posedge CLK);
        conclude();
    end
endmodule

// *** verilog/fscs_pkg.sv ***
// Constants and types of the fail-safe channel status byte block
package fscs_pkg;

    // Channel pair evaluation modes; the unused fourth code acts as deactivated
    typedef enum logic [1:0] {
        FSCS_OFF,
        FSCS_SINGLE,
        FSCS_DUAL
    } fscs_mode_t;

    typedef struct packed {
        fscs_mode_t pair1;
        fscs_mode_t pair0;
    } fscs_cfg_t;

    // Protocol bytes carried in the image, lowest address first in [0]
    typedef logic [3:0][7:0] fscs_proto_t;

    // Image layout
    localparam logic [15:0] FSCS_IN_BYTES  = 16'h0005;
    localparam logic [15:0] FSCS_OUT_BYTES = 16'h0004;

    // Status byte field positions
    localparam int FSCS_BIT_ESTOP0  = 0;
    localparam int FSCS_BIT_ESTOP1  = 1;
    localparam int FSCS_BIT_SINGLE0 = 4;
    localparam int FSCS_BIT_SINGLE2 = 6;

    // Register offsets
    localparam logic [3:0] FSCS_REG_CFG     = 4'h0;
    localparam logic [3:0] FSCS_REG_BASE_LO = 4'h1;
    localparam logic [3:0] FSCS_REG_BASE_HI = 4'h2;
    localparam logic [3:0] FSCS_REG_STATUS  = 4'h3;
    localparam logic [3:0] FSCS_REG_IRQ     = 4'h4;
    localparam logic [3:0] FSCS_REG_MASK    = 4'h5;

    // Interrupt bit positions
    localparam int FSCS_IRQ_CHANGE = 0;
    localparam int FSCS_IRQ_FAULT0 = 1;
    localparam int FSCS_IRQ_FAULT1 = 2;

    // Reset values
    localparam logic [3:0]  FSCS_CFG_RST  = 4'h0;
    localparam logic [15:0] FSCS_BASE_RST = 16'h0000;
    localparam logic [2:0]  FSCS_MASK_RST = 3'h0;

endpackage

// *** verilog/fscs_status.sv ***
// Fail-safe channel status byte with image port and register port
// How it works
// - Five input and four output image bytes sit from a programmable base address.
// - Only input byte zero holds channel states; other bytes carry protocol data.
// - Status bits not assigned by the configuration always read zero.
// - Both pairs deactivated: no evaluation, status byte stays zero.
// - Pair 0 single-channel: bits 4 and 5 follow inputs 0 and 1, 1 closed.
// - Pair 0 dual-channel: bit 0 is 1 unpressed, 0 pressed or error.
// - Both dual: bit 0 reports pair 0 button, bit 1 pair 1 button.
// - Pair 0 dual, pair 1 single: bit 0 button, bits 6 and 7 inputs 2, 3.
// - Both single: bits 4 to 7 follow inputs 0 to 3 ascending.
// - Inputs used by a fail-safe pair are removed from the standard image.
`timescale 1ns/100ps
module fscs_status (
    // Clock, reset, enable
    input  wire logic              CLK,
    input  wire logic              RST_B,
    input  wire logic              CE,
    // Fail-safe input pins
    input  wire logic              SAFE_INPUT_0,
    input  wire logic              SAFE_INPUT_1,
    input  wire logic              SAFE_INPUT_2,
    input  wire logic              SAFE_INPUT_3,
    // Standard image view of the same inputs
    output logic [3:0]             STD_DI,
    // Register port
    input  wire logic [3:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic [7:0]             RDATA,
    output logic                   IRQ,
    // Controller image port
    input  wire logic [15:0]       IMG_ADDR,
    input  wire logic              IMG_RD,
    input  wire logic              IMG_WR,
    input  wire logic [7:0]        IMG_WDATA,
    output logic [7:0]             IMG_RDATA,
    // Protocol engine side
    input  wire fscs_pkg::fscs_proto_t PROTO_TX,
    output fscs_pkg::fscs_proto_t  PROTO_RX
);
    import fscs_pkg::*;

    logic [3:0]  pin;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [3:0]  din;
    fscs_cfg_t   cfg;
    logic [15:0] base;
    logic [7:0]  status;
    logic [7:0]  next_status;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_event;
    logic [15:0] in_off;
    logic        in_hit;
    logic        out_hit;

    assign pin = {SAFE_INPUT_3, SAFE_INPUT_2, SAFE_INPUT_1, SAFE_INPUT_0};

    // Status bits a pair mode owns; undefined codes own nothing
    function automatic logic [7:0] pair_bits(input fscs_mode_t m, input logic hi);
        logic [7:0] r;
        r = 8'h00;
        case (m)
            FSCS_SINGLE: r = hi ? 8'hC0 : 8'h30;
            FSCS_DUAL:   r = hi ? 8'h02 : 8'h01;
            default:     r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] used_bits(input fscs_cfg_t c);
        return pair_bits(c.pair0, 1'b0) | pair_bits(c.pair1, 1'b1);
    endfunction

    // Input pins taken by an active pair
    function automatic logic [3:0] used_pins(input fscs_cfg_t c);
        return {{2{pair_bits(c.pair1, 1'b1) != 8'h00}},
                {2{pair_bits(c.pair0, 1'b0) != 8'h00}}};
    endfunction

    // Three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else if (CE) begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Accept a level only once two stages agree
    generate
        for (genvar i = 0; i < 4; i++) begin : g_filt
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    din[i] <= 1'b0;
                end else if (CE && (sync2[i] == sync3[i])) begin
                    din[i] <= sync3[i];
                end
            end
        end
    endgenerate

    // Channel evaluation; dual channel reads unpressed only when both contacts close
    always_comb begin
        next_status = 8'h00;
        case (cfg.pair0)
            FSCS_SINGLE: next_status[FSCS_BIT_SINGLE0 +: 2] = din[1:0];
            FSCS_DUAL:   next_status[FSCS_BIT_ESTOP0] = din[0] & din[1];
            default:     next_status = next_status;
        endcase
        case (cfg.pair1)
            FSCS_SINGLE: next_status[FSCS_BIT_SINGLE2 +: 2] = din[3:2];
            FSCS_DUAL:   next_status[FSCS_BIT_ESTOP1] = din[2] & din[3];
            default:     next_status = next_status;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status <= 8'h00;
        end else if (CE) begin
            status <= next_status;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            STD_DI <= 4'h0;
        end else if (CE) begin
            STD_DI <= din & ~used_pins(cfg);
        end
    end

    // Configuration registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg      <= fscs_cfg_t'(FSCS_CFG_RST);
            base     <= FSCS_BASE_RST;
            irq_mask <= FSCS_MASK_RST;
        end else if (CE && WR) begin
            case (ADDR)
                FSCS_REG_CFG:     cfg <= fscs_cfg_t'(WDATA[3:0]);
                FSCS_REG_BASE_LO: base[7:0] <= WDATA;
                FSCS_REG_BASE_HI: base[15:8] <= WDATA;
                FSCS_REG_MASK:    irq_mask <= WDATA[2:0];
                default:          base <= base;
            endcase
        end
    end

    // Discrepancy between contacts of a dual pair counts as a fault
    always_comb begin
        irq_event = 3'h0;
        irq_event[FSCS_IRQ_CHANGE] = next_status != status;
        irq_event[FSCS_IRQ_FAULT0] = (cfg.pair0 == FSCS_DUAL) && (din[0] != din[1]);
        irq_event[FSCS_IRQ_FAULT1] = (cfg.pair1 == FSCS_DUAL) && (din[2] != din[3]);
    end

    // Sticky bits; an event in the clearing read survives
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_stat <= 3'h0;
        end else if (CE) begin
            if (RD && (ADDR == FSCS_REG_IRQ)) begin
                irq_stat <= irq_event;
            end else begin
                irq_stat <= irq_stat | irq_event;
            end
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    // Register read data, valid the cycle after the strobe only
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            RDATA <= 8'h00;
            if (RD) begin
                case (ADDR)
                    FSCS_REG_CFG:     RDATA <= {4'h0, cfg};
                    FSCS_REG_BASE_LO: RDATA <= base[7:0];
                    FSCS_REG_BASE_HI: RDATA <= base[15:8];
                    FSCS_REG_STATUS:  RDATA <= status;
                    FSCS_REG_IRQ:     RDATA <= {5'h00, irq_stat};
                    FSCS_REG_MASK:    RDATA <= {5'h00, irq_mask};
                    default:          RDATA <= 8'h00;
                endcase
            end
        end
    end

    assign in_off  = IMG_ADDR - base;
    assign in_hit  = in_off < FSCS_IN_BYTES;
    assign out_hit = in_off < FSCS_OUT_BYTES;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            IMG_RDATA <= 8'h00;
        end else if (CE) begin
            IMG_RDATA <= 8'h00;
            if (IMG_RD && in_hit) begin
                if (in_off == 16'h0000) begin
                    IMG_RDATA <= status;
                end else begin
                    IMG_RDATA <= PROTO_TX[in_off[1:0] - 2'h1];
                end
            end
        end
    end

    // output bytes go to protocol engine
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PROTO_RX <= '0;
        end else if (CE && IMG_WR && out_hit) begin
            PROTO_RX[in_off[1:0]] <= IMG_WDATA;
        end
    end

    // Checks
    sequence s_img_read0;
        CE && IMG_RD && (IMG_ADDR == base);
    endsequence

    property p_zero_unused;
        @(posedge CLK) disable iff (!RST_B)
        $past(CE) |-> ((status & ~used_bits($past(cfg))) == 8'h00);
    endproperty
    a_zero_unused: assert property (p_zero_unused)
        else $error("unassigned status bit set");

    property p_all_off;
        @(posedge CLK) disable iff (!RST_B)
        (CE && used_bits(cfg) == 8'h00) |=> (status == 8'h00);
    endproperty
    a_all_off: assert property (p_all_off)
        else $error("status nonzero with pairs off");

    property p_single0;
        @(posedge CLK) disable iff (!RST_B)
        (CE && cfg.pair0 == FSCS_SINGLE) |=> (status[5:4] == $past(din[1:0]));
    endproperty
    a_single0: assert property (p_single0)
        else $error("bits 4 5 do not follow inputs 0 1");

    property p_dual0;
        @(posedge CLK) disable iff (!RST_B)
        (CE && cfg.pair0 == FSCS_DUAL) |=> (status[0] == ($past(din[0]) & $past(din[1])));
    endproperty
    a_dual0: assert property (p_dual0)
        else $error("pair 0 button bit wrong");

    property p_dual1;
        @(posedge CLK) disable iff (!RST_B)
        (CE && cfg.pair1 == FSCS_DUAL) |=> (status[1] == ($past(din[2]) & $past(din[3])));
    endproperty
    a_dual1: assert property (p_dual1)
        else $error("pair 1 button bit wrong");

    property p_single1;
        @(posedge CLK) disable iff (!RST_B)
        (CE && cfg.pair1 == FSCS_SINGLE) |=> (status[7:6] == $past(din[3:2]));
    endproperty
    a_single1: assert property (p_single1)
        else $error("bits 6 7 do not follow inputs 2 3");

    property p_both_single;
        @(posedge CLK) disable iff (!RST_B)
        (CE && cfg.pair0 == FSCS_SINGLE && cfg.pair1 == FSCS_SINGLE)
            |=> (status == {$past(din), 4'h0});
    endproperty
    a_both_single: assert property (p_both_single)
        else $error("bits 4 to 7 do not follow inputs");

    property p_std_masked;
        @(posedge CLK) disable iff (!RST_B)
        $past(CE) |-> ((STD_DI & used_pins($past(cfg))) == 4'h0);
    endproperty
    a_std_masked: assert property (p_std_masked)
        else $error("fail-safe input in standard image");

    property p_img_status;
        @(posedge CLK) disable iff (!RST_B)
        s_img_read0 |=> (IMG_RDATA == $past(status));
    endproperty
    a_img_status: assert property (p_img_status)
        else $error("image byte zero not status");

    property p_img_outside;
        @(posedge CLK) disable iff (!RST_B)
        (CE && IMG_RD && !in_hit) |=> (IMG_RDATA == 8'h00);
    endproperty
    a_img_outside: assert property (p_img_outside)
        else $error("read outside image not zero");

    property p_reset_clear;
        @(posedge CLK)
        !RST_B |-> (status == 8'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("status not cleared in reset");

endmodule
